// >>> hdl/line_perf_mon.sv
// Line performance monitor: defects, failures and second counters.
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module line_perf_mon
  import line_perf_pkg::*;
#(
  parameter int TENTH_CYC = TENTH_CYCLES
)(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Received frame stream from the framer.
  input  wire logic        frame_start,
  input  wire logic        bit_valid,
  input  wire logic        bit_data,
  input  wire logic        frame_end,
  input  wire logic [5:0]  rx_crc,
  input  wire logic        sync_err,
  input  wire logic        stuff_err,
  // Indicator bits received from upstream regenerators.
  input  wire logic        seg_anom_in,
  input  wire logic        seg_def_in,
  // Line measurements.
  input  wire logic [7:0]  loop_atten,
  input  wire logic [7:0]  snr_margin,
  // Register port.
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  // Indicator bits sent onward and local indications.
  output logic             sega_out,
  output logic             segd_out,
  output logic             sync_word_loss,
  output logic             sync_word_loss_failure,
  output logic             atten_defect,
  output logic             snr_defect,
  output logic             src_addr_clear
);
  localparam int TW = $clog2(TENTH_CYC + 1);

  logic          check_done;
  logic          crc_err;
  logic          sync_err_q;
  logic          stuff_err_q;
  logic          mode_sync_q;
  logic [7:0]    clr_tenths_q;
  logic [7:0]    atten_thr_q;
  logic [7:0]    snr_thr_q;
  logic [1:0]    err_run_q;
  logic [1:0]    ok_run_q;
  logic          sync_word_loss_q;
  logic [TW-1:0] tcnt_q;
  logic [3:0]    tenth_q;
  logic          tenth_tick;
  logic          sec_tick;
  logic [7:0]    def_run_q;
  logic [7:0]    abs_run_q;
  logic [7:0]    age_q;
  logic          fail_q;
  logic          fail_prev_q;
  logic [8:0]    anom_q;
  logic          sync_word_loss_seen_q;
  logic          sec_es;
  logic          sec_ses;
  logic [8:0]    anom_now;
  logic [15:0]   cv_q;
  logic [7:0]    es_q;
  logic [7:0]    ses_q;
  logic [7:0]    sync_loss_second_count_q;
  logic [15:0]   uas_q;
  line_state_e   state_q;
  logic [3:0]    run_q;
  logic [3:0]    es_run_q;
  logic          frame_bad;
  logic [7:0]    clr_wr;
  logic [15:0]   status_w;
  logic [15:0]   rd_mux;

  // Frame check bits recomputed for each frame.
  frame_crc_check u_crc (
    .clk         (clk),
    .rst_b       (rst_b),
    .frame_start (frame_start),
    .bit_valid   (bit_valid),
    .bit_data    (bit_data),
    .frame_end   (frame_end),
    .rx_crc      (rx_crc),
    .check_done  (check_done),
    .crc_err     (crc_err)
  );

  // Framing errors are held to line up with the check result.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_err_q  <= 1'b0;
      stuff_err_q <= 1'b0;
    end else if (frame_end) begin
      sync_err_q  <= sync_err;
      stuff_err_q <= stuff_err;
    end
  end

  assign frame_bad = sync_err_q | (!mode_sync_q & stuff_err_q);

  // Sync word loss defect from runs of bad and good frames.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      err_run_q <= 2'h0;
      ok_run_q  <= 2'h0;
      sync_word_loss_q    <= 1'b0;
    end else if (check_done) begin
      err_run_q <= frame_bad ? ((err_run_q == SYNC_WORD_LOSS_SET_FRAMES) ?
                   err_run_q : err_run_q + 2'h1) : 2'h0;
      ok_run_q  <= frame_bad ? 2'h0 : ((ok_run_q == SYNC_WORD_LOSS_CLR_FRAMES) ?
                   ok_run_q : ok_run_q + 2'h1);
      if (frame_bad && err_run_q == SYNC_WORD_LOSS_SET_FRAMES - 2'h1)
        sync_word_loss_q <= 1'b1;
      else if (!frame_bad && ok_run_q == SYNC_WORD_LOSS_CLR_FRAMES - 2'h1)
        sync_word_loss_q <= 1'b0;
    end
  end

  assign tenth_tick = (tcnt_q == TW'(TENTH_CYC - 1));
  assign sec_tick   = tenth_tick && (tenth_q == TENTHS_PER_SEC - 4'h1);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tcnt_q  <= '0;
      tenth_q <= 4'h0;
    end else begin
      tcnt_q  <= tenth_tick ? '0 : tcnt_q + TW'(1);
      if (tenth_tick)
        tenth_q <= sec_tick ? 4'h0 : tenth_q + 4'h1;
    end
  end

  // Failure set, hold and clear in tenths of a second.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      def_run_q <= 8'h00;
      abs_run_q <= 8'h00;
      age_q     <= 8'h00;
      fail_q    <= 1'b0;
    end else begin
      if (!sync_word_loss_q)
        def_run_q <= 8'h00;
      else if (tenth_tick && def_run_q != FAIL_SET_TENTHS)
        def_run_q <= def_run_q + 8'h01;
      if (sync_word_loss_q)
        abs_run_q <= 8'h00;
      else if (tenth_tick && abs_run_q != 8'hff)
        abs_run_q <= abs_run_q + 8'h01;
      if (!fail_q)
        age_q <= 8'h00;
      else if (tenth_tick && age_q != 8'hff)
        age_q <= age_q + 8'h01;
      if (!fail_q && sync_word_loss_q && def_run_q == FAIL_SET_TENTHS)
        fail_q <= 1'b1;
      else if (fail_q && age_q >= FAIL_HOLD_TENTHS &&
               abs_run_q >= clr_tenths_q)
        fail_q <= 1'b0;
    end
  end

  // Per-second evaluation of the accumulated interval.
  assign anom_now = (anom_q == 9'h1ff) ? anom_q : anom_q + 9'h001;
  assign sec_es   = (anom_q != 9'h000) || sync_word_loss_seen_q;
  assign sec_ses  = (anom_q >= SES_ANOM_MIN) || sync_word_loss_seen_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      anom_q      <= 9'h000;
      sync_word_loss_seen_q <= 1'b0;
    end else begin
      anom_q      <= sec_tick ? {8'h00, crc_err} :
                     (crc_err ? anom_now : anom_q);
      sync_word_loss_seen_q <= sec_tick ? sync_word_loss_q : (sync_word_loss_seen_q | sync_word_loss_q);
    end
  end

  // Modulo counters and availability; nothing clears them but reset.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cv_q     <= 16'h0000;
      es_q     <= 8'h00;
      ses_q    <= 8'h00;
      sync_loss_second_count_q  <= 8'h00;
      uas_q    <= 16'h0000;
      state_q  <= LINE_AVAIL;
      run_q    <= 4'h0;
      es_run_q <= 4'h0;
    end else if (sec_tick) begin
      if (!sec_ses)
        cv_q <= cv_q + {7'h00, anom_q};
      if (sync_word_loss_seen_q)
        sync_loss_second_count_q <= sync_loss_second_count_q + 8'h01;
      case (state_q)
        LINE_AVAIL: begin
          if (sec_ses) begin
            if (run_q == UNAVAIL_RUN - 4'h1) begin
              state_q <= LINE_UNAVAIL;
              run_q   <= 4'h0;
              es_q    <= es_q - 8'h09;
              ses_q   <= ses_q - 8'h09;
              uas_q   <= uas_q + 16'h000a;
            end else begin
              run_q <= run_q + 4'h1;
              es_q  <= es_q + 8'h01;
              ses_q <= ses_q + 8'h01;
            end
          end else begin
            run_q <= 4'h0;
            if (sec_es)
              es_q <= es_q + 8'h01;
          end
        end
        LINE_UNAVAIL: begin
          if (sec_ses) begin
            run_q    <= 4'h0;
            es_run_q <= 4'h0;
            uas_q    <= uas_q + 16'h0001;
          end else if (run_q == UNAVAIL_RUN - 4'h1) begin
            state_q  <= LINE_AVAIL;
            run_q    <= 4'h0;
            es_run_q <= 4'h0;
            uas_q    <= uas_q - 16'h0009;
            es_q     <= es_q + {4'h0, es_run_q} + {7'h00, sec_es};
          end else begin
            run_q    <= run_q + 4'h1;
            es_run_q <= es_run_q + {3'h0, sec_es};
            uas_q    <= uas_q + 16'h0001;
          end
        end
        default: begin
          state_q <= LINE_AVAIL;
          run_q   <= 4'h0;
        end
      endcase
    end
  end

  // Indicators, measurement defects and address reset pulse.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sega_out       <= 1'b0;
      segd_out       <= 1'b0;
      atten_defect   <= 1'b0;
      snr_defect     <= 1'b0;
      src_addr_clear <= 1'b0;
      fail_prev_q    <= 1'b0;
    end else begin
      if (check_done)
        sega_out <= crc_err | seg_anom_in;
      segd_out       <= sync_word_loss_q | seg_def_in;
      atten_defect   <= loop_atten > atten_thr_q;
      snr_defect     <= snr_margin < snr_thr_q;
      src_addr_clear <= fail_q && !fail_prev_q;
      fail_prev_q    <= fail_q;
    end
  end

  assign sync_word_loss = sync_word_loss_q;
  assign sync_word_loss_failure   = fail_q;

  // Register decode; the clear time is kept inside its allowed span.
  assign clr_wr = (reg_wdata[CTRL_CLR_LSB +: 8] < CLR_TENTHS_MIN) ?
                  CLR_TENTHS_MIN :
                  (reg_wdata[CTRL_CLR_LSB +: 8] > CLR_TENTHS_MAX) ?
                  CLR_TENTHS_MAX : reg_wdata[CTRL_CLR_LSB +: 8];
  assign status_w = {9'h000, state_q == LINE_UNAVAIL, segd_out, sega_out,
                     snr_defect, atten_defect, fail_q, sync_word_loss_q};
  assign rd_mux = (reg_addr == ADDR_CTRL)   ?
                    {clr_tenths_q, 7'h00, mode_sync_q} :
                  (reg_addr == ADDR_THRESH) ? {snr_thr_q, atten_thr_q} :
                  (reg_addr == ADDR_STATUS) ? status_w :
                  (reg_addr == ADDR_CV)     ? cv_q :
                  (reg_addr == ADDR_ES)     ? {8'h00, es_q} :
                  (reg_addr == ADDR_SES)    ? {8'h00, ses_q} :
                  (reg_addr == ADDR_SYNC_LOSS_SECOND_COUNT)  ? {8'h00, sync_loss_second_count_q} :
                  (reg_addr == ADDR_UAS)    ? uas_q : 16'h0000;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_sync_q  <= CTRL_SYNC_RST;
      clr_tenths_q <= CLR_TENTHS_RST;
      atten_thr_q  <= ATTEN_THR_RST;
      snr_thr_q    <= SNR_THR_RST;
      reg_rdata    <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == ADDR_CTRL) begin
        mode_sync_q  <= reg_wdata[CTRL_SYNC_BIT];
        clr_tenths_q <= clr_wr;
      end
      if (reg_wr && reg_addr == ADDR_THRESH) begin
        atten_thr_q <= reg_wdata[THR_ATTEN_LSB +: 8];
        snr_thr_q   <= reg_wdata[THR_SNR_LSB +: 8];
      end
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  property p_sync_word_loss_set;
    @(posedge clk) disable iff (!rst_b)
      check_done && frame_bad && err_run_q == 2'h2 |=> sync_word_loss_q;
  endproperty
  a_sync_word_loss_set: assert property (p_sync_word_loss_set)
    else $error("sync loss not set after third bad frame");

  property p_sync_word_loss_clr;
    @(posedge clk) disable iff (!rst_b)
      check_done && !frame_bad && ok_run_q == 2'h1 |=> !sync_word_loss_q;
  endproperty
  a_sync_word_loss_clr: assert property (p_sync_word_loss_clr)
    else $error("sync loss not cleared after second good frame");

  property p_sega;
    @(posedge clk) disable iff (!rst_b)
      check_done && crc_err |=> sega_out;
  endproperty
  a_sega: assert property (p_sega)
    else $error("segment anomaly missing after check mismatch");

  property p_segd;
    @(posedge clk) disable iff (!rst_b)
      sync_word_loss_q ##1 sync_word_loss_q |-> segd_out;
  endproperty
  a_segd: assert property (p_segd)
    else $error("segment defect missing during sync loss");

  property p_atten;
    @(posedge clk) disable iff (!rst_b)
      $stable(loop_atten) && $stable(atten_thr_q) ##1 1'b1
      |-> atten_defect == ($past(loop_atten) > $past(atten_thr_q));
  endproperty
  a_atten: assert property (p_atten)
    else $error("attenuation defect does not follow threshold");

  property p_snr;
    @(posedge clk) disable iff (!rst_b)
      snr_margin < snr_thr_q |=> snr_defect;
  endproperty
  a_snr: assert property (p_snr)
    else $error("margin defect missing below threshold");

  property p_fail_set;
    @(posedge clk) disable iff (!rst_b)
      !fail_q && sync_word_loss_q && def_run_q == FAIL_SET_TENTHS |=> fail_q;
  endproperty
  a_fail_set: assert property (p_fail_set)
    else $error("failure not declared after contiguous defect");

  property p_fail_hold;
    @(posedge clk) disable iff (!rst_b)
      fail_q && age_q < FAIL_HOLD_TENTHS |=> fail_q;
  endproperty
  a_fail_hold: assert property (p_fail_hold)
    else $error("failure dropped before minimum hold");

  property p_sync_loss_second_count;
    @(posedge clk) disable iff (!rst_b)
      sec_tick && sync_word_loss_seen_q |=> sync_loss_second_count_q == $past(sync_loss_second_count_q) + 8'h01;
  endproperty
  a_sync_loss_second_count: assert property (p_sync_loss_second_count)
    else $error("sync loss second not counted");

  property p_cv_inh;
    @(posedge clk) disable iff (!rst_b)
      sec_tick && sec_ses |=> $stable(cv_q);
  endproperty
  a_cv_inh: assert property (p_cv_inh)
    else $error("code violations counted in severe second");

  property p_uas;
    @(posedge clk) disable iff (!rst_b)
      sec_tick && state_q == LINE_UNAVAIL && sec_ses
      |=> uas_q == $past(uas_q) + 16'h0001;
  endproperty
  a_uas: assert property (p_uas)
    else $error("unavailable second not counted");

  property p_addr;
    @(posedge clk) disable iff (!rst_b)
      !fail_q ##1 fail_q |=> src_addr_clear;
  endproperty
  a_addr: assert property (p_addr)
    else $error("source address clear missing on failure");
endmodule
`default_nettype wire

// >>> hdl/line_perf_pkg.sv
// Constants, register map and timing for the line performance monitor.
// Contract
// - Recompute frame check bits, flag mismatching frame.
// - Segment anomaly on any regenerator CRC anomaly.
// - Plesiochronous: three bad framing frames set loss.
// - Synchronous: three bad sync frames set loss.
// - Segment defect follows any regenerator sync loss.
// - Attenuation above threshold raises attenuation defect.
// - Margin below threshold raises margin defect.
// - Sync loss failure after 2.5 s defect.
// - Failure held 2 s, cleared after chosen absence.
// - Code violation count increments per CRC anomaly.
// - Errored second on anomaly or sync loss.
// - Severe second on 50 anomalies or loss.
// - Sync loss second counted, never inhibited.
// - Ten severe seconds enter, ten clean leave unavailability.
// - Unavailable seconds always counted, never inhibited.
// - Errored and severe seconds retroactively inhibited when unavailable.
// - Code violations inhibited during severe seconds.
// - Free-running wrap-around counters, read by differences.
// - Errored second counter is eight bits wide.
// - Sync loss failure resets own source address.
package line_perf_pkg;
  // Register word addresses.
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_THRESH = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_CV     = 4'h3;
  localparam logic [3:0] ADDR_ES     = 4'h4;
  localparam logic [3:0] ADDR_SES    = 4'h5;
  localparam logic [3:0] ADDR_SYNC_LOSS_SECOND_COUNT  = 4'h6;
  localparam logic [3:0] ADDR_UAS    = 4'h7;
  // Field positions.
  localparam int CTRL_SYNC_BIT   = 0;
  localparam int CTRL_CLR_LSB    = 8;
  localparam int THR_ATTEN_LSB   = 0;
  localparam int THR_SNR_LSB     = 8;
  // Reset values.
  localparam logic       CTRL_SYNC_RST = 1'b0;
  localparam logic [7:0] CLR_TENTHS_RST = 8'h1e;
  localparam logic [7:0] ATTEN_THR_RST  = 8'hff;
  localparam logic [7:0] SNR_THR_RST    = 8'h00;
  // Frame check polynomial, serial form without the top term.
  localparam logic [5:0] CRC_POLY = 6'h03;
  // Framing run lengths.
  localparam logic [1:0] SYNC_WORD_LOSS_SET_FRAMES = 2'h3;
  localparam logic [1:0] SYNC_WORD_LOSS_CLR_FRAMES = 2'h2;
  // Per-second thresholds.
  localparam logic [8:0] SES_ANOM_MIN = 9'h032;
  localparam logic [3:0] UNAVAIL_RUN  = 4'ha;
  // Time base: a tenth of a second at the 100 MHz clock.
  localparam int TENTH_MS         = 100;
  localparam int CLK_KHZ          = 100000;
  localparam int TENTH_CYCLES     = TENTH_MS * CLK_KHZ;
  localparam logic [3:0] TENTHS_PER_SEC = 4'ha;
  // Failure timing in tenths of a second.
  localparam logic [7:0] FAIL_SET_TENTHS  = 8'h19;
  localparam logic [7:0] FAIL_HOLD_TENTHS = 8'h14;
  localparam logic [7:0] CLR_TENTHS_MIN   = 8'h14;
  localparam logic [7:0] CLR_TENTHS_MAX   = 8'hc8;
  // Line availability states.
  typedef enum logic [1:0] {
    LINE_AVAIL   = 2'b01,
    LINE_UNAVAIL = 2'b10
  } line_state_e;
endpackage

// >>> hdl/frame_crc_check.sv
// Serial frame check bit recomputation and compare for one frame.
`timescale 1ns/10ps
`default_nettype none
module frame_crc_check
  import line_perf_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Received frame bits.
  input  wire logic       frame_start,
  input  wire logic       bit_valid,
  input  wire logic       bit_data,
  input  wire logic       frame_end,
  input  wire logic [5:0] rx_crc,
  // Result, one cycle after frame end.
  output logic            check_done,
  output logic            crc_err
);
  logic [5:0] crc_q;
  logic [5:0] crc_d;
  logic       fb;

  // Feedback and next remainder for one covered bit.
  assign fb    = bit_data ^ crc_q[5];
  assign crc_d = frame_start ? 6'h00 :
                 bit_valid ? ({crc_q[4:0], 1'b0} ^ (fb ? CRC_POLY : 6'h00))
                           : crc_q;

  // Remainder register and per-frame verdict.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      crc_q      <= 6'h00;
      check_done <= 1'b0;
      crc_err    <= 1'b0;
    end else begin
      crc_q      <= crc_d;
      check_done <= frame_end;
      crc_err    <= frame_end && (crc_q != rx_crc);
    end
  end
endmodule
`default_nettype wire

// >>> verification/db_poller.sv
// Database manager model that polls the monitor's counters.
`timescale 1ns/10ps
`default_nettype none
module db_poller (
  // Clock.
  input  wire logic        clk,
  // Register port, master side.
  output logic [3:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata
);
  logic [15:0] prev  [3:7];
  logic [15:0] delta [3:7];
  int          hist_15m [3:7][0:32];

  // Idle bus from time zero.
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    foreach (prev[k]) prev[k] = 16'h0000;
  end

  // One write strobe cycle.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // One read strobe cycle, data taken in the following cycle only.
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask

  // difference into bins
  // Modulo differences, so a wrapped or decremented counter still adds up.
  task automatic poll();
    logic [15:0] c;
    for (int k = 3; k <= 7; k++) begin
      rd(4'(k), c);
      delta[k] = (c - prev[k]) & ((k == 3 || k == 7) ? 16'hffff : 16'h00ff);
      prev[k] = c;
      hist_15m[k][0] += int'(delta[k]);
    end
  endtask
endmodule
`default_nettype wire

// >>> verification/test_line_perf_mon.sv
// Self-checking testbench for the line performance monitor.
`timescale 1ns/10ps
`default_nettype none
module test_line_perf_mon;
  import line_perf_pkg::*;
  localparam logic [3:0] PAY = 4'h9;
  logic        clk, rst_b, frame_start, bit_valid, bit_data, frame_end;
  logic        sync_err, stuff_err, seg_anom_in, seg_def_in;
  logic [5:0]  rx_crc;
  logic [7:0]  loop_atten, snr_margin;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, v;
  logic        reg_wr, reg_rd, sega_out, segd_out, sync_word_loss;
  logic        sync_word_loss_failure, atten_defect, snr_defect, src_addr_clear;
  logic        p_loss = 1'b0, p_fail = 1'b0;
  int          errors = 0, total_checks = 0, cyc = 0, n_clr = 0;
  int          t_lon, t_loff, t_fon, t_foff, t_clr;

  line_perf_mon #(.TENTH_CYC(100)) u_dut (
    .clk(clk), .rst_b(rst_b), .frame_start(frame_start),
    .bit_valid(bit_valid), .bit_data(bit_data), .frame_end(frame_end),
    .rx_crc(rx_crc), .sync_err(sync_err), .stuff_err(stuff_err),
    .seg_anom_in(seg_anom_in), .seg_def_in(seg_def_in),
    .loop_atten(loop_atten), .snr_margin(snr_margin),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sega_out(sega_out),
    .segd_out(segd_out), .sync_word_loss(sync_word_loss),
    .sync_word_loss_failure(sync_word_loss_failure), .atten_defect(atten_defect),
    .snr_defect(snr_defect), .src_addr_clear(src_addr_clear));

  db_poller u_db (
    .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cycle count since release and edge times; a second is 1000 cycles.
  always @(posedge clk) begin
    if (rst_b) cyc <= cyc + 1;
    p_loss <= sync_word_loss;
    p_fail <= sync_word_loss_failure;
    if (sync_word_loss && !p_loss) t_lon <= cyc;
    if (!sync_word_loss && p_loss) t_loff <= cyc;
    if (sync_word_loss_failure && !p_fail) t_fon <= cyc;
    if (!sync_word_loss_failure && p_fail) t_foff <= cyc;
    if (src_addr_clear) n_clr <= n_clr + 1;
    if (src_addr_clear) t_clr <= cyc;
  end

  task automatic chk(input logic [15:0] got, exp, input string m);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e,
                        input string m);
    u_db.rd(a, v);
    chk(v, e, m);
  endtask

  // Reference check bits, msb first, x^6+x+1, zero start.
  function automatic logic [5:0] crc6(input logic [3:0] d);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 3; i >= 0; i--)
      c = {c[4:0], 1'b0} ^ ((d[i] ^ c[5]) ? 6'h03 : 6'h00);
    return c;
  endfunction

  // One six-cycle frame; bad flips the last check bit.
  task automatic send_frame(input logic bad, se, ste);
    @(posedge clk);
    frame_start <= 1'b1;
    for (int i = 3; i >= 0; i--) begin
      @(posedge clk);
      frame_start <= 1'b0;
      bit_valid <= 1'b1;
      bit_data <= PAY[i];
    end
    @(posedge clk);
    bit_valid <= 1'b0;
    frame_end <= 1'b1;
    rx_crc <= crc6(PAY) ^ {5'h00, bad};
    sync_err <= se;
    stuff_err <= ste;
    @(posedge clk);
    frame_end <= 1'b0;
  endtask

  // Frame then indications; t = {bad, sync, stuff, sega, loss}.
  task automatic fr_chk(input logic [4:0] t);
    send_frame(t[4], t[3], t[2]);
    repeat (2) @(posedge clk);
    #1;
    chk(16'(sega_out), 16'(t[1]), "sega");
    chk(16'(sync_word_loss), 16'(t[0]), "loss");
    chk(16'(segd_out), 16'(t[0]), "segd");
  endtask

  task automatic wait_phase(input int p);
    int n;
    n = 0;
    while (cyc % 1000 != p && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      errors++;
      final_report();
    end
  endtask

  task automatic t_regs();
    rd_chk(ADDR_CTRL, {CLR_TENTHS_RST, 8'h00}, "ctrl reset");
    rd_chk(ADDR_THRESH, 16'h00ff, "thresh reset");
    u_db.wr(ADDR_STATUS, 16'hffff);
    rd_chk(ADDR_STATUS, 16'h0000, "status read only");
    u_db.wr(4'h8, 16'hffff);
    rd_chk(4'h8, 16'h0000, "unmapped");
    u_db.wr(ADDR_CTRL, 16'h0500);
    rd_chk(ADDR_CTRL, {CLR_TENTHS_MIN, 8'h00}, "clear clamp");
    $display("test regs done");
  endtask

  task automatic t_frames();
    logic [4:0] tp [7] = '{5'h00, 5'h12, 5'h04, 5'h04, 5'h05, 5'h01, 5'h00};
    logic [4:0] ts [8] = '{5'h04, 5'h04, 5'h04, 5'h08, 5'h08, 5'h09,
                           5'h01, 5'h00};
    foreach (tp[i]) fr_chk(tp[i]);
    u_db.wr(ADDR_CTRL, 16'h1401);
    foreach (ts[i]) fr_chk(ts[i]);
    seg_anom_in <= 1'b1;
    fr_chk(5'h02);
    seg_anom_in <= 1'b0;
    seg_def_in <= 1'b1;
    repeat (3) @(posedge clk);
    chk(16'(segd_out), 16'h0001, "segd upstream");
    seg_def_in <= 1'b0;
    $display("test frames done");
  endtask

  task automatic t_thresh();
    u_db.wr(ADDR_THRESH, 16'h2040);
    for (int i = 0; i < 3; i++) begin
      loop_atten <= 8'h3f + 8'(i);
      snr_margin <= 8'h21 - 8'(i);
      repeat (3) @(posedge clk);
      chk(16'(atten_defect), 16'(i == 2), "atten");
      chk(16'(snr_defect), 16'(i == 2), "snr");
    end
    loop_atten <= 8'h00;
    snr_margin <= 8'hff;
    $display("test thresholds done");
  endtask

  task automatic t_seconds();
    int n [3] = '{3, 49, 50};
    wait_phase(100);
    u_db.poll();
    foreach (n[j]) begin
      repeat (n[j]) send_frame(1'b1, 1'b0, 1'b0);
      wait_phase(100);
      u_db.poll();
      chk(u_db.delta[ADDR_CV], 16'(n[j] >= 50 ? 0 : n[j]), "cv");
      chk(u_db.delta[ADDR_ES], 16'h0001, "es");
      chk(u_db.delta[ADDR_SES], 16'(n[j] >= 50), "ses");
    end
    $display("test seconds done");
  endtask

  task automatic t_outage();
    int stop, c0;
    @(posedge clk);
    wait_phase(100);
    u_db.poll();
    c0 = n_clr;
    stop = cyc + 12000;
    while (cyc < stop) send_frame(1'b0, 1'b1, 1'b0);
    rd_chk(ADDR_STATUS, 16'h0063, "status in outage");
    chk(16'(t_fon - t_lon inside {[2000:3000]}), 16'h1, "fail set");
    chk(16'(n_clr - c0), 16'h0001, "addr clear pulse");
    chk(16'(t_clr - t_fon), 16'h0001, "addr clear time");
    repeat (2) send_frame(1'b0, 1'b0, 1'b0);
    repeat (11) begin
      @(posedge clk);
      wait_phase(100);
    end
    chk(16'(t_foff - t_loff inside {[1800:2200]}), 16'h1, "fail clr");
    chk(16'(t_foff - t_fon >= 2000), 16'h1, "fail hold");
    u_db.poll();
    chk(u_db.delta[ADDR_UAS], 16'd13, "uas");
    chk(u_db.delta[ADDR_ES], 16'h0000, "es inhibit");
    chk(u_db.delta[ADDR_SES], 16'h0000, "ses inhibit");
    chk(u_db.delta[ADDR_SYNC_LOSS_SECOND_COUNT], 16'd13, "sync_loss_second_count");
    chk(u_db.delta[ADDR_CV], 16'h0000, "cv outage");
    $display("test outage done");
  endtask

  // Watchdog against a hang.
  initial begin
    #1000000;
    errors++;
    final_report();
  end

  // Main sequence.
  initial begin
    rst_b = 1'b0;
    {frame_start, bit_valid, bit_data, frame_end, sync_err} = 5'h00;
    {stuff_err, seg_anom_in, seg_def_in} = 3'h0;
    rx_crc = 6'h00;
    loop_atten = 8'h00;
    snr_margin = 8'hff;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_frames();
    t_thresh();
    t_seconds();
    t_outage();
    final_report();
  end
endmodule
`default_nettype wire
